//--- rtl/mfi_ctrl.sv
// Multi-function interrupt controller: source flags, groups, global enable,
// vector request and wake-up.
// Assumes the core end on the mfi_if link and source event pulses synchronous
// to sys_clk_in.
`include "mfi_defines.svh"

module mfi_ctrl (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Link to the core
  mfi_if.ctrl link,
  // Timer module match events, one pulse per match
  input wire logic [`MFI_NUM_TM-1:0] tm_cmp_a_match_in,
  input wire logic [`MFI_NUM_TM-1:0] tm_cmp_p_match_in,
  // Low supply detector event
  input wire logic low_supply_detect_in,
  // EEPROM write cycle end event
  input wire logic eeprom_write_end_in,
  // Serial interface events
  input wire logic serial_byte_done_in,
  input wire logic i2c_addr_match_in,
  input wire logic i2c_timeout_in,
  // Status for the user side
  output logic [`MFI_NUM_SRC-1:0] src_flag_out,
  output logic [`MFI_NUM_GRP-1:0] grp_flag_out,
  output logic wake_out
);

  mfi_pkg::ctrl_state_s state;
  mfi_pkg::ctrl_state_s next_state;

  // Hardware events in source bit order
  mfi_pkg::src_vec_t hw_event;
  always_comb begin
    hw_event = '0;
    for (int t = 0; t < `MFI_NUM_TM; t++) begin
      hw_event[`MFI_SRC_TM0_A + 2 * t] = tm_cmp_a_match_in[t];
      hw_event[`MFI_SRC_TM0_A + 2 * t + 1] = tm_cmp_p_match_in[t];
    end
    hw_event[`MFI_SRC_LOW_SUPPLY] = low_supply_detect_in;
    hw_event[`MFI_SRC_EEPROM] = eeprom_write_end_in;
    hw_event[`MFI_SRC_SERIAL] = serial_byte_done_in | i2c_addr_match_in
                                | i2c_timeout_in;
  end

  // Service is taken only against a request the core actually saw
  logic serviced;
  assign serviced = link.call_ack & state.call_req;

  mfi_pkg::src_vec_t src_rise;
  mfi_pkg::grp_vec_t grp_set;
  mfi_pkg::grp_vec_t grp_ready;
  mfi_pkg::grp_vec_t grp_drop;
  logic found;

  always_comb begin
    next_state = state;
    src_rise = '0;
    grp_set = '0;
    grp_ready = '0;
    grp_drop = '0;
    found = 1'b0;

    // Source flags: set wins over software clear; service leaves them alone
    next_state.src_flag = (state.src_flag & ~link.src_clr) | hw_event
                          | link.src_set;
    if (link.src_en_wr) begin
      next_state.src_en = link.src_en_data;
    end
    if (link.grp_en_wr) begin
      next_state.grp_en = link.grp_en_data;
    end

    // Group flags follow a rising member flag
    src_rise = next_state.src_flag & ~state.src_flag;
    for (int g = 0; g < `MFI_NUM_GRP; g++) begin
      grp_set[g] = |(src_rise & mfi_pkg::grp_members(2'(g)));
    end
    if (serviced) begin
      grp_drop[state.call_group] = 1'b1;
    end
    // A member flag rise in the service cycle keeps the group flag
    next_state.grp_flag = (state.grp_flag & ~link.grp_clr & ~grp_drop)
                          | grp_set;

    // Global enable: service clears it last so it wins over software
    if (link.gie_wr) begin
      next_state.gie = link.gie_data;
    end
    if (link.return_from_interrupt) begin
      next_state.gie = 1'b1;
    end
    if (serviced) begin
      next_state.gie = 1'b0;
    end

    // Request selection on the coming state, so the outputs are registered
    for (int g = 0; g < `MFI_NUM_GRP; g++) begin
      grp_ready[g] = next_state.grp_flag[g] & next_state.grp_en[g]
                     & |(next_state.src_flag & next_state.src_en
                         & mfi_pkg::grp_members(2'(g)));
    end
    next_state.call_req = 1'b0;
    next_state.call_group = state.call_group;
    for (int g = 0; g < `MFI_NUM_GRP; g++) begin
      if (grp_ready[g] && !found) begin
        found = 1'b1;
        next_state.call_group = 2'(g);
      end
    end
    // Stack level is the one seen now; a push in flight is caught by the ack
    next_state.call_req = found & next_state.gie & ~link.stack_full
                          & ~serviced;

    // Wake on any source or group flag rise, enables play no part
    next_state.wake = |src_rise
                      | |(next_state.grp_flag & ~state.grp_flag);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state.src_flag <= `MFI_SRC_RST;
      state.src_en <= `MFI_SRC_RST;
      state.grp_flag <= `MFI_GRP_RST;
      state.grp_en <= `MFI_GRP_RST;
      state.gie <= `MFI_GIE_RST;
      state.call_req <= 1'b0;
      state.call_group <= 2'h0;
      state.wake <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Link outputs
  assign link.call_req = state.call_req;
  assign link.call_group = state.call_group;
  assign link.src_flag = state.src_flag;
  assign link.src_en = state.src_en;
  assign link.grp_flag = state.grp_flag;
  assign link.grp_en = state.grp_en;
  assign link.gie = state.gie;
  assign link.wake = state.wake;

  // User-side status
  assign src_flag_out = state.src_flag;
  assign grp_flag_out = state.grp_flag;
  assign wake_out = state.wake;

endmodule : mfi_ctrl

//--- rtl/mfi_defines.svh
// Constants shared by the multi-function interrupt controller and the core end.
// Assumes inclusion by bare name from files under rtl/.
`ifndef MFI_DEFINES_SVH
`define MFI_DEFINES_SVH

// Counts
`define MFI_NUM_SRC 9
`define MFI_NUM_GRP 4
`define MFI_NUM_TM 3
`define MFI_PC_W 13
`define MFI_STACK_DEPTH 8
`define MFI_SP_W 4

// Source bit positions
`define MFI_SRC_TM0_A 0
`define MFI_SRC_LOW_SUPPLY 6
`define MFI_SRC_EEPROM 7
`define MFI_SRC_SERIAL 8

// Group membership masks
`define MFI_GRP0_MASK 9'h003
`define MFI_GRP1_MASK 9'h00c
`define MFI_GRP2_MASK 9'h030
`define MFI_GRP3_MASK 9'h1c0

// Reset values
`define MFI_SRC_RST 9'h000
`define MFI_GRP_RST 4'h0
`define MFI_GIE_RST 1'b0

// Vector addresses of the groups
`define MFI_VEC_BASE 13'h000c
`define MFI_VEC_STEP 13'h0004

`endif

//--- rtl/mfi_pkg.sv
// Types of the multi-function interrupt controller and of the core end.
// Assumes mfi_defines.svh is reachable by bare name.
`include "mfi_defines.svh"

package mfi_pkg;

  typedef logic [`MFI_NUM_SRC-1:0] src_vec_t;
  typedef logic [`MFI_NUM_GRP-1:0] grp_vec_t;
  typedef logic [`MFI_PC_W-1:0] pc_t;
  typedef logic [`MFI_SP_W-1:0] sp_t;

  typedef enum logic {core_run, core_asleep} core_mode_e;

  typedef struct packed {
    src_vec_t src_flag;
    src_vec_t src_en;
    grp_vec_t grp_flag;
    grp_vec_t grp_en;
    logic gie;
    logic call_req;
    logic [1:0] call_group;
    logic wake;
  } ctrl_state_s;

  typedef struct packed {
    core_mode_e mode;
    sp_t sp;
    logic [`MFI_STACK_DEPTH-1:0][`MFI_PC_W-1:0] stack;
    logic call_ack;
    logic return_from_interrupt;
    pc_t vector_pc;
    logic vector_valid;
    pc_t ret_pc;
    logic ret_valid;
    src_vec_t src_set;
    src_vec_t src_clr;
    logic src_en_wr;
    src_vec_t src_en_data;
    logic grp_en_wr;
    grp_vec_t grp_en_data;
    grp_vec_t grp_clr;
    logic gie_wr;
    logic gie_data;
  } core_state_s;

  // Members of one group
  function automatic src_vec_t grp_members(input logic [1:0] g);
    case (g)
      2'h0: grp_members = `MFI_GRP0_MASK;
      2'h1: grp_members = `MFI_GRP1_MASK;
      2'h2: grp_members = `MFI_GRP2_MASK;
      default: grp_members = `MFI_GRP3_MASK;
    endcase
  endfunction : grp_members

endpackage : mfi_pkg

//--- rtl/mfi_if.sv
// Link between the interrupt controller and the core's interrupt sequencer.
// Assumes one common clock; both ends are driven from it.
interface mfi_if;
  // Core to controller
  mfi_pkg::src_vec_t src_set;
  mfi_pkg::src_vec_t src_clr;
  logic src_en_wr;
  mfi_pkg::src_vec_t src_en_data;
  logic grp_en_wr;
  mfi_pkg::grp_vec_t grp_en_data;
  mfi_pkg::grp_vec_t grp_clr;
  logic gie_wr;
  logic gie_data;
  logic stack_full;
  logic call_ack;
  logic return_from_interrupt;
  // Controller to core
  logic call_req;
  logic [1:0] call_group;
  mfi_pkg::src_vec_t src_flag;
  mfi_pkg::src_vec_t src_en;
  mfi_pkg::grp_vec_t grp_flag;
  mfi_pkg::grp_vec_t grp_en;
  logic gie;
  logic wake;

  modport ctrl (
    input src_set, src_clr, src_en_wr, src_en_data, grp_en_wr, grp_en_data,
    input grp_clr, gie_wr, gie_data, stack_full, call_ack, return_from_interrupt,
    output call_req, call_group, src_flag, src_en, grp_flag, grp_en, gie, wake
  );

  modport core (
    output src_set, src_clr, src_en_wr, src_en_data, grp_en_wr, grp_en_data,
    output grp_clr, gie_wr, gie_data, stack_full, call_ack, return_from_interrupt,
    input call_req, call_group, src_flag, src_en, grp_flag, grp_en, gie, wake
  );
endinterface : mfi_if

//--- rtl/mfi_core.sv
// Core end: interrupt sequencer with return stack and flag commands.
// Assumes the controller on the mfi_if link and user commands synchronous
// to sys_clk_in.
`include "mfi_defines.svh"

module mfi_core (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Link to the controller
  mfi_if.core link,
  // Program flow
  input wire logic insn_boundary_in,
  input wire logic [`MFI_PC_W-1:0] pc_in,
  input wire logic call_in,
  input wire logic ret_in,
  input wire logic return_from_interrupt_in,
  input wire logic sleep_in,
  // Flag and enable commands, pulses
  input wire logic [`MFI_NUM_SRC-1:0] src_set_in,
  input wire logic [`MFI_NUM_SRC-1:0] src_clr_in,
  input wire logic src_en_wr_in,
  input wire logic [`MFI_NUM_SRC-1:0] src_en_data_in,
  input wire logic grp_en_wr_in,
  input wire logic [`MFI_NUM_GRP-1:0] grp_en_data_in,
  input wire logic [`MFI_NUM_GRP-1:0] grp_clr_in,
  input wire logic gie_wr_in,
  input wire logic gie_data_in,
  // Results
  output logic [`MFI_PC_W-1:0] vector_pc_out,
  output logic vector_valid_out,
  output logic [`MFI_PC_W-1:0] ret_pc_out,
  output logic ret_valid_out,
  output logic sleeping_out
);

  mfi_pkg::core_state_s state;
  mfi_pkg::core_state_s next_state;
  logic full;
  logic take;

  assign full = state.sp == `MFI_SP_W'(`MFI_STACK_DEPTH);
  // Held off for one cycle after an ack, while the request drops
  assign take = (state.mode == mfi_pkg::core_run) & link.call_req & insn_boundary_in
                & ~full & ~state.call_ack;

  always_comb begin
    next_state = state;
    next_state.call_ack = take;
    next_state.return_from_interrupt = 1'b0;
    next_state.vector_valid = 1'b0;
    next_state.ret_valid = 1'b0;
    next_state.src_set = src_set_in;
    next_state.src_clr = src_clr_in;
    next_state.src_en_wr = src_en_wr_in;
    next_state.src_en_data = src_en_data_in;
    next_state.grp_en_wr = grp_en_wr_in;
    next_state.grp_en_data = grp_en_data_in;
    next_state.grp_clr = grp_clr_in;
    next_state.gie_wr = gie_wr_in;
    next_state.gie_data = gie_data_in;
    case (state.mode)
      mfi_pkg::core_run: begin
        if (take) begin
          // Only the program counter is saved
          next_state.stack[state.sp[`MFI_SP_W-2:0]] = pc_in;
          next_state.sp = state.sp + `MFI_SP_W'(1);
          next_state.vector_pc = `MFI_VEC_BASE
                                 + `MFI_VEC_STEP * `MFI_PC_W'(link.call_group);
          next_state.vector_valid = 1'b1;
        end else if (call_in && !full) begin
          // A call inside a service routine eats the same stack
          next_state.stack[state.sp[`MFI_SP_W-2:0]] = pc_in;
          next_state.sp = state.sp + `MFI_SP_W'(1);
        end else if ((ret_in || return_from_interrupt_in) && state.sp != '0) begin
          next_state.sp = state.sp - `MFI_SP_W'(1);
          next_state.ret_pc = state.stack[next_state.sp[`MFI_SP_W-2:0]];
          next_state.ret_valid = 1'b1;
          next_state.return_from_interrupt = return_from_interrupt_in;
        end else if (sleep_in) begin
          next_state.mode = mfi_pkg::core_asleep;
        end
      end
      mfi_pkg::core_asleep: begin
        if (link.wake) begin
          next_state.mode = mfi_pkg::core_run;
        end
      end
      default: begin
        next_state.mode = mfi_pkg::core_run;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign link.src_set = state.src_set;
  assign link.src_clr = state.src_clr;
  assign link.src_en_wr = state.src_en_wr;
  assign link.src_en_data = state.src_en_data;
  assign link.grp_en_wr = state.grp_en_wr;
  assign link.grp_en_data = state.grp_en_data;
  assign link.grp_clr = state.grp_clr;
  assign link.gie_wr = state.gie_wr;
  assign link.gie_data = state.gie_data;
  assign link.stack_full = full;
  assign link.call_ack = state.call_ack;
  assign link.return_from_interrupt = state.return_from_interrupt;

  assign vector_pc_out = state.vector_pc;
  assign vector_valid_out = state.vector_valid;
  assign ret_pc_out = state.ret_pc;
  assign ret_valid_out = state.ret_valid;
  assign sleeping_out = state.mode == mfi_pkg::core_asleep;

endmodule : mfi_core

//--- tb/mfi_sva.sv
// Checker of the controller to core link: assertions and covers.
// Assumes one clock and an active low asynchronous reset; placed beside the link.
`include "mfi_defines.svh"

module mfi_sva (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Link signals
  input wire logic [`MFI_NUM_SRC-1:0] src_flag,
  input wire logic [`MFI_NUM_SRC-1:0] src_en,
  input wire logic [`MFI_NUM_SRC-1:0] src_clr,
  input wire logic [`MFI_NUM_GRP-1:0] grp_flag,
  input wire logic [`MFI_NUM_GRP-1:0] grp_en,
  input wire logic gie,
  input wire logic call_req,
  input wire logic [1:0] call_group,
  input wire logic call_ack,
  input wire logic return_from_interrupt,
  input wire logic stack_full,
  input wire logic wake
);
  logic [8:0] prev_flag;
  logic [8:0] rise;
  logic [3:0] pend;
  logic [3:0] grp_rise;
  logic [3:0][8:0] mask;

  assign mask = {`MFI_GRP3_MASK, `MFI_GRP2_MASK, `MFI_GRP1_MASK, `MFI_GRP0_MASK};
  assign rise = src_flag & ~prev_flag;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      prev_flag <= 9'h000;
    else
      prev_flag <= src_flag;
  end

  // Groups that could be vectored now, if the global enable allows
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      pend[g] = grp_flag[g] & grp_en[g] & (|(src_flag & src_en & mask[g]));
      grp_rise[g] = |(rise & mask[g]);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  grp_set_a: assert property (|grp_rise |-> (grp_flag & grp_rise) == grp_rise)
    else $error("group flag missed a member rise");
  wake_rise_a: assert property (|rise |-> wake)
    else $error("flag rise without wake pulse");
  call_cond_a: assert property (call_req |-> gie && pend[call_group])
    else $error("call request without enabled pending group");
  prio_low_a: assert property (call_req |-> (pend & ((4'h1 << call_group) - 4'h1)) == 4'h0)
    else $error("lower pending group skipped");
  ack_cause_a: assert property (call_ack |-> $past(call_req) && !$past(stack_full))
    else $error("vector taken without request or with full stack");
  svc_clear_a: assert property (call_ack |=> !gie && !grp_flag[$past(call_group)])
    else $error("service left group flag or global enable set");
  flag_keep_a: assert property (src_clr == 9'h000 |=> (src_flag & $past(src_flag)) == $past(src_flag))
    else $error("source flag dropped without clear");
  return_from_interrupt_gie_a: assert property (return_from_interrupt && !call_ack |=> gie)
    else $error("global enable not set by return from interrupt");
  ack_pulse_a: assert property (call_ack |=> !call_ack)
    else $error("vector call longer than one cycle");

  cover property (call_ack && call_group == 2'h3);
  cover property (return_from_interrupt);
  cover property (wake && !call_req);
endmodule : mfi_sva

//--- tb/multi_function_interrupt_ctrl_test.sv
// Bench: controller and core joined by the link, both user sides driven.
// Assumes the rtl files and the checker are compiled first.
`include "mfi_defines.svh"
`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module multi_function_interrupt_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rstn_in, low_supply_detect_in, eeprom_write_end_in;
  logic serial_byte_done_in, i2c_addr_match_in, i2c_timeout_in, wake_out;
  logic [2:0] tm_cmp_a_match_in, tm_cmp_p_match_in;
  logic [8:0] src_flag_out, src_set_in, src_clr_in, src_en_data_in;
  logic [3:0] grp_flag_out, grp_en_data_in, grp_clr_in;
  logic insn_boundary_in, call_in, ret_in, return_from_interrupt_in, sleep_in, src_en_wr_in;
  logic grp_en_wr_in, gie_wr_in, gie_data_in, vector_valid_out, ret_valid_out, sleeping_out;
  logic [12:0] pc_in, vector_pc_out, ret_pc_out, ev;
  logic [8:0] last_flag;
  logic [12:0] exp_vec[$], exp_ret[$], stk[$];
  logic [31:0] seed = 32'heb93;
  int errors = 0, n_checks = 0, cycles = 0, si, g;

  mfi_if bus ();
  mfi_ctrl mfi_ctrl_inst (.sys_clk_in, .rstn_in, .link(bus), .tm_cmp_a_match_in,
    .tm_cmp_p_match_in, .low_supply_detect_in, .eeprom_write_end_in, .serial_byte_done_in,
    .i2c_addr_match_in, .i2c_timeout_in, .src_flag_out, .grp_flag_out, .wake_out);
  mfi_core mfi_core_inst (.sys_clk_in, .rstn_in, .link(bus), .insn_boundary_in, .pc_in,
    .call_in, .ret_in, .return_from_interrupt_in, .sleep_in, .src_set_in, .src_clr_in, .src_en_wr_in,
    .src_en_data_in, .grp_en_wr_in, .grp_en_data_in, .grp_clr_in, .gie_wr_in, .gie_data_in,
    .vector_pc_out, .vector_valid_out, .ret_pc_out, .ret_valid_out, .sleeping_out);
  mfi_sva mfi_sva_inst (.sys_clk_in, .rstn_in, .src_flag(bus.src_flag), .src_en(bus.src_en),
    .src_clr(bus.src_clr), .grp_flag(bus.grp_flag), .grp_en(bus.grp_en), .gie(bus.gie),
    .call_req(bus.call_req), .call_group(bus.call_group), .call_ack(bus.call_ack),
    .return_from_interrupt(bus.return_from_interrupt), .stack_full(bus.stack_full), .wake(bus.wake));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Commands: 0 source enables, 1 group enables, 2 global enable, 3 clear, 4 set, 5 group clear
  task automatic cmd(input int k, input logic [8:0] d);
    @(posedge sys_clk_in);
    src_en_data_in <= d;
    grp_en_data_in <= d[3:0];
    gie_data_in <= d[0];
    case (k)
      0: src_en_wr_in <= 1'b1;
      1: grp_en_wr_in <= 1'b1;
      2: gie_wr_in <= 1'b1;
      3: src_clr_in <= d;
      4: src_set_in <= d;
      default: grp_clr_in <= d[3:0];
    endcase
    @(posedge sys_clk_in);
    {src_en_wr_in, grp_en_wr_in, gie_wr_in, src_clr_in, src_set_in, grp_clr_in} <= '0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask : cmd

  // Events 0..5 timer matches, 6 low supply, 7 eeprom, 8..10 the serial causes
  task automatic fire(input int s);
    @(posedge sys_clk_in);
    if (s < 6 && s % 2 == 0)
      tm_cmp_a_match_in[s / 2] <= 1'b1;
    if (s < 6 && s % 2 == 1)
      tm_cmp_p_match_in[s / 2] <= 1'b1;
    {low_supply_detect_in, eeprom_write_end_in} <= {s == 6, s == 7};
    {serial_byte_done_in, i2c_addr_match_in, i2c_timeout_in} <= {s == 8, s == 9, s == 10};
    @(posedge sys_clk_in);
    {tm_cmp_a_match_in, tm_cmp_p_match_in} <= 6'h00;
    {low_supply_detect_in, eeprom_write_end_in, serial_byte_done_in} <= 3'h0;
    {i2c_addr_match_in, i2c_timeout_in} <= 2'h0;
  endtask : fire

  // Program flow: 0 plain return, 1 return from interrupt, 2 call
  task automatic flow(input int k);
    @(posedge sys_clk_in);
    if (k == 2)
      stk.push_back(pc_in);
    else
      exp_ret.push_back(stk.pop_back());
    {call_in, ret_in, return_from_interrupt_in} <= {k == 2, k == 0, k == 1};
    @(posedge sys_clk_in);
    {call_in, ret_in, return_from_interrupt_in} <= 3'h0;
  endtask : flow

  // A short wait also exposes any vector that was not expected
  task automatic drain();
    repeat (40)
      if (exp_vec.size() + exp_ret.size() != 0)
        @(posedge sys_clk_in);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("pending_results", 0, exp_vec.size() + exp_ret.size())
  endtask : drain

  task automatic newpc(input int grp);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    pc_in <= seed[12:0];
    if (grp >= 0)
      exp_vec.push_back(`MFI_VEC_BASE + `MFI_VEC_STEP * grp);
  endtask : newpc

  always @(negedge sys_clk_in) begin
    if (vector_valid_out) begin
      ev = exp_vec.size() ? exp_vec.pop_front() : 13'h1fff;
      stk.push_back(pc_in);
      `CHK("vector_pc", ev, vector_pc_out)
    end
    if (ret_valid_out) begin
      ev = exp_ret.size() ? exp_ret.pop_front() : 13'h1fff;
      `CHK("return_pc", ev, ret_pc_out)
    end
    // Any source flag rise must come with the wake pulse, enables aside
    if (|(src_flag_out & ~last_flag))
      `CHK("wake_out", 1'b1, wake_out)
    last_flag = src_flag_out;
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    {rstn_in, tm_cmp_a_match_in, tm_cmp_p_match_in, low_supply_detect_in} = '0;
    {eeprom_write_end_in, serial_byte_done_in, i2c_addr_match_in, i2c_timeout_in} = '0;
    {pc_in, call_in, ret_in, return_from_interrupt_in, sleep_in, src_set_in, src_clr_in} = '0;
    {src_en_wr_in, src_en_data_in, grp_en_wr_in, grp_en_data_in, grp_clr_in} = '0;
    {gie_wr_in, gie_data_in} = '0;
    insn_boundary_in = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    cmd(0, 9'h1ff);
    cmd(1, 9'h00f);
    for (int s = 0; s < 11; s++) begin
      si = (s > 8) ? 8 : s;
      g = (si < 6) ? si / 2 : 3;
      cmd(2, 9'h001);
      newpc(g);
      fire(s);
      drain();
      `CHK("src_kept", 1'b1, src_flag_out[si])
      `CHK("grp_cleared", 1'b0, grp_flag_out[g])
      `CHK("gie_cleared", 1'b0, bus.gie)
      flow(s % 2);
      drain();
      `CHK("gie_after_return", s % 2 == 1, bus.gie)
      cmd(3, 9'h1ff);
      `CHK("src_cleared", 9'h000, src_flag_out)
    end
    // Disabled source keeps its flag and is served once enabled
    cmd(0, 9'h000);
    fire(7);
    drain();
    `CHK("flag_held", 1'b1, src_flag_out[7])
    newpc(3);
    cmd(0, 9'h1ff);
    // Global enable was left cleared by the last plain return
    cmd(2, 9'h001);
    drain();
    flow(1);
    cmd(3, 9'h1ff);
    // Three groups at once: served lowest first, plain return blocks the rest
    cmd(2, 9'h000);
    @(posedge sys_clk_in);
    tm_cmp_a_match_in <= 3'h5;
    i2c_timeout_in <= 1'b1;
    @(posedge sys_clk_in);
    tm_cmp_a_match_in <= 3'h0;
    i2c_timeout_in <= 1'b0;
    newpc(0);
    cmd(2, 9'h001);
    drain();
    flow(0);
    drain();
    `CHK("gie_after_ret", 1'b0, bus.gie)
    newpc(2);
    cmd(2, 9'h001);
    drain();
    exp_vec.push_back(`MFI_VEC_BASE + `MFI_VEC_STEP * 3);
    flow(1);
    drain();
    flow(1);
    cmd(3, 9'h1ff);
    // Full stack holds the vector back until one return frees a level
    repeat (8) begin
      newpc(-1);
      flow(2);
    end
    fire(0);
    drain();
    `CHK("grp_waiting", 1'b1, grp_flag_out[0])
    newpc(0);
    flow(0);
    drain();
    flow(1);
    repeat (7) flow(0);
    drain();
    cmd(3, 9'h1ff);
    // Wake-up ignores enables; a preset flag cannot wake
    cmd(2, 9'h000);
    cmd(0, 9'h000);
    cmd(4, 9'h080);
    @(posedge sys_clk_in);
    sleep_in <= 1'b1;
    @(posedge sys_clk_in);
    sleep_in <= 1'b0;
    fire(7);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("still_asleep", 1'b1, sleeping_out)
    fire(6);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("woken", 1'b0, sleeping_out)
    cmd(3, 9'h1ff);
    wrap_up();
  end
endmodule : multi_function_interrupt_ctrl_test
